// ---- hdl/dbv_consts.svh ----
// Register map, field positions, reset values and pin indices of the bank
`ifndef DBV_CONSTS_SVH
`define DBV_CONSTS_SVH
`define DBV_ADDR_BUCK1_CODE 8'h00
`define DBV_ADDR_BUCK2_CODE 8'h01
`define DBV_ADDR_BUCK1_CMD  8'h02
`define DBV_ADDR_BUCK2_CMD  8'h03
`define DBV_ADDR_HEALTH     8'h04
`define DBV_REG_RESET       8'h00
`define DBV_GO_BIT          7
`define DBV_CMD_WRITE_MASK  8'h77
`define DBV_SLEW_LSB        4
`define DBV_MODE_LSB        1
`define DBV_OFF_BIT         0
`define DBV_MODE_PIN        2'h0
`define DBV_MODE_PWM        2'h1
`define DBV_MODE_SKIP       2'h2
`define DBV_SLAVE_BASE      7'h60
`define DBV_SEL_GROUND      2'h0
`define DBV_SEL_OPEN        2'h1
`define DBV_SEL_HIGH        2'h2
`define DBV_MV_BASE         11'h2A8
`define DBV_MV_STEP         11'h00A
`define DBV_ACK_SLOT        4'h8
`define DBV_STRAP_WAIT      3'h7
`define DBV_SCL_SETTLE      3'h5
`define DBV_IN_SCL          0
`define DBV_IN_SDA          1
`define DBV_IN_WR           2
`define DBV_IN_PTR          3
`define DBV_IN_EN1          4
`define DBV_IN_EN2          5
`define DBV_IN_SHARE        6
`define DBV_IN_MODEPIN      7
`define DBV_IN_HOT          8
`define DBV_IN_PG1          9
`define DBV_IN_PG2          10
`define DBV_IN_TICK         11
`define DBV_IN_AGND         12
`define DBV_IN_AHIGH        13
`define DBV_IN_COUNT        14
`endif

// ---- hdl/dbv_pkg.sv ----
// Types shared by the VID register bank and its slew ramp
`default_nettype none
`include "dbv_consts.svh"
package dbv_pkg;
   typedef enum logic [2:0] {PH_ADDR, PH_REG, PH_DATA, PH_READ, PH_IDLE}
      dbv_phase_type;

   typedef struct packed {
      dbv_phase_type phase;
      logic [3:0]    bitCnt;
      logic [7:0]    shift;
   } dbv_rx_type;

   typedef struct packed {
      logic       sdaOe;
      logic       ptrReq;
      logic       wrReq;
      logic [7:0] txShift;
      logic [7:0] regAddr;
      logic [7:0] data;
   } dbv_tx_type;

   typedef struct packed {
      logic [`DBV_IN_COUNT-1:0] s1;
      logic [`DBV_IN_COUNT-1:0] s2;
      logic [`DBV_IN_COUNT-1:0] s3;
      logic [`DBV_IN_COUNT-1:0] filt;
      logic [`DBV_IN_COUNT-1:0] prev;
      logic [2:0]               strapCnt;
      logic [2:0]               sclHighCnt;
      logic [6:0]               devAddr;
      logic [7:0]               pointer;
      logic [7:0]               rdHold;
      logic [1:0][7:0]          code;
      logic [1:0][7:0]          cmd;
      logic [1:0][6:0]          applied;
      logic [1:0][2:0]          slew;
      logic [1:0]               goOut;
      logic [1:0]               offOut;
      logic [1:0]               skipOut;
      logic                     tick;
      logic                     linkHold;
      logic                     sdaOut;
   } dbv_core_type;

   typedef struct packed {
      logic [6:0]  present;
      logic [6:0]  divCnt;
      logic [10:0] mv;
   } dbv_ramp_type;
endpackage
`default_nettype wire

// ---- hdl/dbv_slew_ramp.sv ----
// Slew-limited voltage code ramp for one converter
`timescale 1ns/10ps
`default_nettype none
module dbv_slew_ramp
   import dbv_pkg::*;
(
   input  wire logic        core_clk,    // Core clock
   input  wire logic        rst,         // Synchronous reset, active high
   input  wire logic        stepTick,    // One pulse per switching cycle
   input  wire logic [2:0]  slewCode,    // Cycles per step is 2**slewCode
   input  wire logic [6:0]  targetCode,  // Code the output heads for
   output logic      [6:0]  presentCode, // Code applied now
   output logic      [10:0] presentMv    // Present output voltage in mV
);
   dbv_ramp_type st;
   dbv_ramp_type next_st;
   logic [7:0]   stepSpan;

   assign stepSpan = 8'h01 << slewCode;
   assign presentCode = st.present;
   assign presentMv = st.mv;

   always_comb begin
      next_st = st;
      if (stepTick) begin
         if (st.present == targetCode) begin
            next_st.divCnt = 7'h00;
         end else if ({1'b0, st.divCnt} >= stepSpan - 8'h01) begin
            next_st.divCnt = 7'h00;
            if (st.present < targetCode) begin
               next_st.present = st.present + 7'h01;
            end else begin
               next_st.present = st.present - 7'h01;
            end
         end else begin
            next_st.divCnt = st.divCnt + 7'h01;
         end
      end
      next_st.mv = `DBV_MV_BASE + `DBV_MV_STEP * {4'h0, next_st.present};
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st <= '0;
         st.mv <= `DBV_MV_BASE;
      end else begin
         st <= next_st;
      end
   end

   mv_scale_a: assert property (@(posedge core_clk) disable iff (rst)
      presentMv == `DBV_MV_BASE + `DBV_MV_STEP * {4'h0, presentCode})
      else $error("output voltage does not match the code");

   step_single_a: assert property (@(posedge core_clk) disable iff (rst)
      $changed(presentCode) |-> $past(stepTick)
         && (presentCode == $past(presentCode) + 7'h01
         || presentCode == $past(presentCode) - 7'h01))
      else $error("code moved off a switching cycle or by more than a step");
endmodule
`default_nettype wire

// ---- hdl/dbv_vid_regs.sv ----
// Serial-bus register bank of the dual step-down regulator
// Overview of operation
// - Acknowledge own address and each written byte low during ninth clock
// - Commit write at falling edge of data LSB
// - Both enable pins low blocks register updates
// - Software disable bits leave the bus working
// - Current sharing ignores converter-2 registers
// - Go bit gates bus voltage control
// - Code maps to 680 mV plus 10 mV steps
// - Slew field sets cycles per voltage step
// - Mode field picks pin, PWM or pulse skip
// - Command bit 0 turns the output off
// - Slave address 0x60 to 0x62 from pin
// - Seven-bit addressing only, no general call
// - Health register shows hot and power-good flags
`timescale 1ns/10ps
`default_nettype none
module dbv_vid_regs
   import dbv_pkg::*;
(
   input  wire logic        core_clk,              // Core clock, 10 MHz
   input  wire logic        rst,                   // Synchronous reset
   input  wire logic        sclClk,                // Serial clock from master
   input  wire logic        sdaIn,                 // Serial data wire level
   output logic             sdaOut,                // Drive level, always low
   output logic             sdaOe,                 // High pulls data low
   input  wire logic        addrPinGround,         // Address pin tied low
   input  wire logic        addrPinHigh,           // Address pin tied high
   input  wire logic        buck1EnablePin,        // Converter 1 enable pin
   input  wire logic        buck2EnablePin,        // Converter 2 enable pin
   input  wire logic        currentShareMode,      // Converters paralleled
   input  wire logic        modePinPulseSkip,      // Mode pin asks skip
   input  wire logic        overTemp,              // Die above 125 C
   input  wire logic        output1InRegulation,   // Output 1 power good
   input  wire logic        output2InRegulation,   // Output 2 power good
   input  wire logic        switchClk,             // Switching-cycle clock
   output logic             buck1GoFlag,           // Bus owns voltage 1
   output logic             buck2GoFlag,           // Bus owns voltage 2
   output logic [6:0]       buck1VoltageCode,      // Ramped code 1
   output logic [6:0]       buck2VoltageCode,      // Ramped code 2
   output logic [10:0]      buck1TargetMv,         // Ramped voltage 1, mV
   output logic [10:0]      buck2TargetMv,         // Ramped voltage 2, mV
   output logic             buck1OutputOff,        // Output 1 disabled
   output logic             buck2OutputOff,        // Output 2 disabled
   output logic             buck1PulseSkipSwitching, // Converter 1 skips
   output logic             buck2PulseSkipSwitching  // Converter 2 skips
);
   dbv_core_type     st;
   dbv_core_type     next_st;
   dbv_rx_type       rx;
   dbv_rx_type       next_rx;
   dbv_tx_type       tx;
   dbv_tx_type       next_tx;
   logic [`DBV_IN_COUNT-1:0] pinVec;
   logic             linkHold;
   logic             sclF;
   logic             startCond;
   logic             stopCond;
   logic             wrEdge;
   logic             ptrEdge;
   logic             enOk;
   logic             share;
   logic             addrMatch;
   logic [7:0]       txSrc;
   logic [1:0][10:0] rampMv;
   logic [1:0][6:0]  rampCode;

   assign pinVec = {addrPinHigh, addrPinGround, switchClk,
                    output2InRegulation, output1InRegulation, overTemp,
                    modePinPulseSkip, currentShareMode, buck2EnablePin,
                    buck1EnablePin, tx.ptrReq, tx.wrReq, sdaIn, sclClk};
   assign linkHold = st.linkHold;
   assign sclF = st.filt[`DBV_IN_SCL];
   assign startCond = sclF && st.sclHighCnt >= `DBV_SCL_SETTLE
                      && st.prev[`DBV_IN_SDA] && !st.filt[`DBV_IN_SDA];
   assign stopCond = sclF && st.sclHighCnt >= `DBV_SCL_SETTLE
                     && !st.prev[`DBV_IN_SDA] && st.filt[`DBV_IN_SDA];
   assign wrEdge = st.filt[`DBV_IN_WR] && !st.prev[`DBV_IN_WR];
   assign ptrEdge = st.filt[`DBV_IN_PTR] && !st.prev[`DBV_IN_PTR];
   // Software disable bits play no part here, only the pins
   assign enOk = st.filt[`DBV_IN_EN1] || st.filt[`DBV_IN_EN2];
   assign share = st.filt[`DBV_IN_SHARE];

   function automatic logic [7:0] readMux(input dbv_core_type s);
      case (s.pointer)
         `DBV_ADDR_BUCK1_CODE: readMux = s.code[0];
         `DBV_ADDR_BUCK2_CODE: readMux = s.code[1];
         `DBV_ADDR_BUCK1_CMD:  readMux = s.cmd[0];
         `DBV_ADDR_BUCK2_CMD:  readMux = s.cmd[1];
         `DBV_ADDR_HEALTH:     readMux = {5'h00, s.filt[`DBV_IN_HOT],
                                          s.filt[`DBV_IN_PG2],
                                          s.filt[`DBV_IN_PG1]};
         default:              readMux = 8'h00;
      endcase
   endfunction

   // Core domain: pin filters, bus conditions, registers and outputs
   always_comb begin
      logic [7:0] selCode;
      logic [7:0] selCmd;
      logic [1:0] sel;
      selCode = 8'h00;
      selCmd = 8'h00;
      sel = `DBV_SEL_OPEN;
      next_st = st;
      next_st.s1 = pinVec;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // A bit moves only once the second and third stage agree
      next_st.filt = (st.s2 & ~(st.s2 ^ st.s3)) | (st.filt & (st.s2 ^ st.s3));
      next_st.prev = st.filt;
      next_st.tick = st.filt[`DBV_IN_TICK] && !st.prev[`DBV_IN_TICK];
      next_st.sdaOut = 1'b0;
      // Aliasing of a fast clock must not fake a start or stop
      next_st.sclHighCnt = (sclF && st.prev[`DBV_IN_SCL])
         ? st.sclHighCnt + {2'h0, st.sclHighCnt != 3'h7} : 3'h0;
      if (st.strapCnt != `DBV_STRAP_WAIT) begin
         next_st.strapCnt = st.strapCnt + 3'h1;
         if (st.filt[`DBV_IN_AGND]) begin
            sel = `DBV_SEL_GROUND;
         end else if (st.filt[`DBV_IN_AHIGH]) begin
            sel = `DBV_SEL_HIGH;
         end
         next_st.devAddr = `DBV_SLAVE_BASE | {5'h00, sel};
      end
      // Link logic is held clear from a start or stop until the clock
      // is low again, which also restarts the byte framing.
      if (startCond || stopCond) begin
         next_st.linkHold = 1'b1;
      end else if (!sclF) begin
         next_st.linkHold = 1'b0;
      end
      if (ptrEdge) begin
         next_st.pointer = tx.regAddr;
      end
      if (wrEdge && enOk) begin
         unique case (st.pointer)
            `DBV_ADDR_BUCK1_CODE: next_st.code[0] = tx.data;
            `DBV_ADDR_BUCK2_CODE: begin
               if (!share) begin
                  next_st.code[1] = tx.data;
               end
            end
            `DBV_ADDR_BUCK1_CMD: next_st.cmd[0] = tx.data & `DBV_CMD_WRITE_MASK;
            `DBV_ADDR_BUCK2_CMD: begin
               if (!share) begin
                  next_st.cmd[1] = tx.data & `DBV_CMD_WRITE_MASK;
               end
            end
            default: begin
            end
         endcase
      end
      // Read data is a snapshot; it stays still while the link shifts it
      if (ptrEdge || wrEdge) begin
         next_st.rdHold = readMux(next_st);
      end
      for (int i = 0; i < 2; i++) begin
         // Paralleled converters both follow the converter-1 settings
         selCode = (share && i == 1) ? st.code[0] : st.code[i];
         selCmd = (share && i == 1) ? st.cmd[0] : st.cmd[i];
         if (selCode[`DBV_GO_BIT]) begin
            next_st.applied[i] = selCode[6:0];
         end
         next_st.goOut[i] = selCode[`DBV_GO_BIT];
         next_st.slew[i] = selCmd[`DBV_SLEW_LSB+:3];
         next_st.offOut[i] = selCmd[`DBV_OFF_BIT];
         unique case (selCmd[`DBV_MODE_LSB+:2])
            `DBV_MODE_PIN:  next_st.skipOut[i] = st.filt[`DBV_IN_MODEPIN];
            `DBV_MODE_PWM:  next_st.skipOut[i] = 1'b0;
            `DBV_MODE_SKIP: next_st.skipOut[i] = 1'b1;
            default:        next_st.skipOut[i] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st <= '0;
         st.linkHold <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Link domain, rising edges: sample data and frame the bytes
   assign addrMatch = (rx.shift[7:1] == st.devAddr);

   always_comb begin
      next_rx = rx;
      if (rx.bitCnt != `DBV_ACK_SLOT) begin
         next_rx.shift = {rx.shift[6:0], sdaIn};
         next_rx.bitCnt = rx.bitCnt + 4'h1;
      end else begin
         next_rx.bitCnt = 4'h0;
         unique case (rx.phase)
            PH_ADDR: begin
               if (!addrMatch) begin
                  next_rx.phase = PH_IDLE;
               end else if (rx.shift[0]) begin
                  next_rx.phase = PH_READ;
               end else begin
                  next_rx.phase = PH_REG;
               end
            end
            PH_REG:  next_rx.phase = PH_DATA;
            PH_DATA: next_rx.phase = PH_IDLE;
            PH_READ: begin
               if (sdaIn) begin
                  next_rx.phase = PH_IDLE;
               end
            end
            PH_IDLE: next_rx.phase = PH_IDLE;
         endcase
      end
   end

   always_ff @(posedge sclClk or posedge linkHold) begin
      if (linkHold) begin
         rx <= '0;
      end else begin
         rx <= next_rx;
      end
   end

   // Link domain, falling edges: drive acknowledge and read data
   assign txSrc = (rx.bitCnt == 4'h0) ? st.rdHold : tx.txShift;

   always_comb begin
      next_tx = tx;
      if (rx.bitCnt == `DBV_ACK_SLOT) begin
         next_tx.sdaOe = (rx.phase == PH_ADDR && addrMatch)
                         || rx.phase == PH_REG || rx.phase == PH_DATA;
         if (rx.phase == PH_REG) begin
            next_tx.regAddr = rx.shift;
            next_tx.ptrReq = 1'b1;
         end
         if (rx.phase == PH_DATA) begin
            next_tx.data = rx.shift;
            next_tx.wrReq = 1'b1;
         end
      end else begin
         next_tx.ptrReq = 1'b0;
         next_tx.wrReq = 1'b0;
         if (rx.phase == PH_READ) begin
            next_tx.sdaOe = !txSrc[7];
            next_tx.txShift = {txSrc[6:0], 1'b0};
         end else begin
            next_tx.sdaOe = 1'b0;
         end
      end
   end

   always_ff @(negedge sclClk or posedge linkHold) begin
      if (linkHold) begin
         tx <= '0;
      end else begin
         tx <= next_tx;
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_ramp
      dbv_slew_ramp u_ramp (
         .core_clk    (core_clk),
         .rst         (rst),
         .stepTick    (st.tick),
         .slewCode    (st.slew[g]),
         .targetCode  (st.applied[g]),
         .presentCode (rampCode[g]),
         .presentMv   (rampMv[g])
      );
   end

   assign sdaOut = st.sdaOut;
   assign sdaOe = tx.sdaOe;
   assign buck1GoFlag = st.goOut[0];
   assign buck2GoFlag = st.goOut[1];
   assign buck1VoltageCode = rampCode[0];
   assign buck2VoltageCode = rampCode[1];
   assign buck1TargetMv = rampMv[0];
   assign buck2TargetMv = rampMv[1];
   assign buck1OutputOff = st.offOut[0];
   assign buck2OutputOff = st.offOut[1];
   assign buck1PulseSkipSwitching = st.skipOut[0];
   assign buck2PulseSkipSwitching = st.skipOut[1];

   shutdown_block_a: assert property (@(posedge core_clk) disable iff (rst)
      (wrEdge && !enOk) |=> ($stable(st.code) && $stable(st.cmd)))
      else $error("register changed in hardware shutdown");

   write_commit_a: assert property (@(posedge core_clk) disable iff (rst)
      (wrEdge && enOk && st.pointer == `DBV_ADDR_BUCK1_CODE)
      |=> (st.code[0] == $past(tx.data)))
      else $error("written byte not stored");

   share_ignore_a: assert property (@(posedge core_clk) disable iff (rst)
      (share && st.filt[`DBV_IN_SHARE] == st.prev[`DBV_IN_SHARE])
      |=> ($stable(st.code[1]) && $stable(st.cmd[1])
           && st.goOut[1] == $past(st.code[0][`DBV_GO_BIT])))
      else $error("converter-2 registers acted on in sharing mode");

   reserved_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      ((st.cmd[0] | st.cmd[1]) & ~`DBV_CMD_WRITE_MASK) == 8'h00)
      else $error("reserved command bit set");

   go_gate_a: assert property (@(posedge core_clk) disable iff (rst)
      !st.code[0][`DBV_GO_BIT] |=> $stable(st.applied[0]))
      else $error("target moved with go bit clear");

   ack_drive_a: assert property (@(posedge sclClk) disable iff (linkHold)
      (rx.bitCnt == `DBV_ACK_SLOT
       && (rx.phase == PH_REG || rx.phase == PH_DATA)) |-> sdaOe)
      else $error("byte not acknowledged");

   read_release_a: assert property (@(posedge sclClk) disable iff (linkHold)
      (rx.bitCnt == `DBV_ACK_SLOT && rx.phase == PH_READ) |-> !sdaOe)
      else $error("data held low in master acknowledge slot");

   addr_ignore_a: assert property (@(posedge sclClk) disable iff (linkHold)
      (rx.bitCnt == `DBV_ACK_SLOT && rx.phase == PH_ADDR && !addrMatch)
      |-> !sdaOe)
      else $error("foreign address acknowledged");
endmodule
`default_nettype wire

// ---- verif/dbv_bus_master.sv ----
// Serial bus master model that reaches the register bank
`timescale 1ns/10ps
`default_nettype none
module dbv_bus_master (
   output var logic sclClk,  // Serial clock, stands high between frames
   output var logic sdaPull, // High pulls the data wire low
   input  wire logic sdaWire  // Resolved data wire level
);
   // Slow phases give the core time to see start, stop and acknowledge
   localparam int LONG = 1000;

   initial begin
      sclClk = 1'b1;
      sdaPull = 1'b0;
   end

   // Data moves only while the clock is low; result is high if either
   // end of the high phase saw the wire high
   task automatic clkBit(input logic p, input int lo, input int hi,
                         output logic s);
      logic s0;
      sclClk = 1'b0;
      #(lo/2) sdaPull = p;
      #(lo/2) sclClk = 1'b1;
      #1 s0 = sdaWire;
      #(hi-2) s = s0 | sdaWire;
      #1;
   endtask

   // Also serves as repeated start: ends with the clock high
   task automatic start();
      sclClk = 1'b0;
      #LONG sdaPull = 1'b0;
      #LONG sclClk = 1'b1;
      #LONG sdaPull = 1'b1;
      #LONG;
   endtask

   task automatic stop();
      sclClk = 1'b0;
      #LONG sdaPull = 1'b1;
      #LONG sclClk = 1'b1;
      #LONG sdaPull = 1'b0;
      #LONG;
   endtask

   // Ninth clock always released: device answers, or reader gives NACK
   task automatic xfer(input logic [7:0] tx, input logic rdMode,
                       output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clkBit(~rdMode & ~tx[i], (i == 7) ? LONG : 80, 80, s);
         rx[i] = s;
      end
      clkBit(1'b0, LONG, LONG, s);
      ack = ~s;
   endtask

   task automatic writeReg(input logic [6:0] dev, input logic [7:0] ra,
                           input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic       a0, a1, a2;
      start();
      xfer({dev, 1'b0}, 1'b0, r, a0);
      xfer(ra, 1'b0, r, a1);
      xfer(d, 1'b0, r, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask

   task automatic readReg(input logic [6:0] dev, input logic [7:0] ra,
                          output logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic       a0, a1, a2, n;
      start();
      xfer({dev, 1'b0}, 1'b0, r, a0);
      xfer(ra, 1'b0, r, a1);
      start();
      xfer({dev, 1'b1}, 1'b0, r, a2);
      xfer(8'hFF, 1'b1, d, n);
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule
`default_nettype wire

// ---- verif/dbv_vid_regs_test.sv ----
// Self-checking bench of the serial-bus register bank
`timescale 1ns/10ps
`default_nettype none
module dbv_vid_regs_test
   import dbv_pkg::*;
;
   logic        core_clk, rst, sclClk, sdaPull, sdaOut, sdaOe, sdaWire;
   logic        addrPinGround, addrPinHigh, buck1EnablePin, buck2EnablePin;
   logic        currentShareMode, modePinPulseSkip, overTemp, switchClk;
   logic        output1InRegulation, output2InRegulation;
   logic        buck1GoFlag, buck2GoFlag, buck1OutputOff, buck2OutputOff;
   logic        buck1PulseSkipSwitching, buck2PulseSkipSwitching;
   logic [6:0]  buck1VoltageCode, buck2VoltageCode, dev;
   logic [10:0] buck1TargetMv, buck2TargetMv;
   logic [7:0]  rd;
   logic        ok;
   int          mismatches, compares;

   // Open-drain wire with a pull-up
   assign sdaWire = ~(sdaPull | (sdaOe & ~sdaOut));

   dbv_vid_regs i_dbv_vid_regs (.core_clk, .rst, .sclClk,
      .sdaIn(sdaWire), .sdaOut, .sdaOe, .addrPinGround, .addrPinHigh,
      .buck1EnablePin, .buck2EnablePin, .currentShareMode,
      .modePinPulseSkip, .overTemp, .output1InRegulation,
      .output2InRegulation, .switchClk, .buck1GoFlag, .buck2GoFlag,
      .buck1VoltageCode, .buck2VoltageCode, .buck1TargetMv, .buck2TargetMv,
      .buck1OutputOff, .buck2OutputOff, .buck1PulseSkipSwitching,
      .buck2PulseSkipSwitching);

   dbv_bus_master i_dbv_bus_master (.sclClk, .sdaPull, .sdaWire);

   always #50 core_clk = ~core_clk;

   task automatic end_of_test();
      if (mismatches == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [10:0] exp,
                      input logic [10:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic wr(input logic [7:0] ra, input logic [7:0] d);
      i_dbv_bus_master.writeReg(dev, ra, d, ok);
      chk("write ack", 1'b1, ok);
      cyc(20);
   endtask

   task automatic rdChk(input logic [7:0] ra, input logic [7:0] exp);
      i_dbv_bus_master.readReg(dev, ra, rd, ok);
      chk("read ack", 1'b1, ok);
      chk("read data", exp, rd);
      cyc(2);
   endtask

   // Switching cycles slow enough to clear the input filter
   task automatic ticks(input int n);
      repeat (n) begin
         switchClk = 1'b1;
         cyc(6);
         switchClk = 1'b0;
         cyc(6);
      end
   endtask

   task automatic doReset(input logic g, input logic h);
      cyc(1);
      addrPinGround = g;
      addrPinHigh = h;
      rst = 1'b1;
      cyc(10);
      rst = 1'b0;
      cyc(12);
   endtask

   task automatic resetScen();
      chk("mv1 reset", 11'h2A8, buck1TargetMv);
      chk("mv2 reset", 11'h2A8, buck2TargetMv);
      chk("go reset", 2'h0, {buck1GoFlag, buck2GoFlag});
      chk("sda level", 1'b0, sdaOut);
      for (int r = 0; r < 6; r++)
         rdChk(8'(r), 8'h00);
   endtask

   task automatic goScen();
      int i;
      wr(8'h00, 8'h85);
      for (i = 0; i < 50 && buck1GoFlag !== 1'b1; i++)
         cyc(1);
      if (i == 50) begin
         mismatches++;
         $display("MISMATCH go flag expected 1 seen %b", buck1GoFlag);
         end_of_test();
      end
      ticks(4);
      chk("code after 4", 7'h04, buck1VoltageCode);
      ticks(1);
      chk("code after 5", 7'h05, buck1VoltageCode);
      chk("mv code 5", 11'h2DA, buck1TargetMv);
      wr(8'h00, 8'h10);
      chk("go cleared", 1'b0, buck1GoFlag);
      ticks(2);
      chk("code held", 7'h05, buck1VoltageCode);
   endtask

   // Any two switching cycles hold exactly one step at slew code 001
   task automatic slewScen();
      wr(8'h02, 8'h10);
      wr(8'h00, 8'h87);
      ticks(2);
      chk("slew half", 7'h06, buck1VoltageCode);
      ticks(2);
      chk("slew end", 7'h07, buck1VoltageCode);
      chk("mv code 7", 11'h2EE, buck1TargetMv);
   endtask

   task automatic modeScen();
      modePinPulseSkip = 1'b1;
      for (int m = 0; m < 4; m++) begin
         wr(8'h02, {5'h00, 2'(m), 1'b0});
         chk("skip", (m == 0 || m == 2), buck1PulseSkipSwitching);
      end
      wr(8'h02, 8'hFF);
      rdChk(8'h02, 8'h77);
      chk("off1", 1'b1, buck1OutputOff);
   endtask

   task automatic shutScen();
      buck1EnablePin = 1'b0;
      buck2EnablePin = 1'b0;
      cyc(6);
      wr(8'h00, 8'h9F);
      rdChk(8'h00, 8'h87);
      buck1EnablePin = 1'b1;
      buck2EnablePin = 1'b1;
      cyc(6);
      wr(8'h03, 8'h01);
      rdChk(8'h03, 8'h01);
      rdChk(8'h02, 8'h77);
      chk("off2", 1'b1, buck2OutputOff);
   endtask

   task automatic shareScen();
      currentShareMode = 1'b1;
      wr(8'h03, 8'h00);
      rdChk(8'h03, 8'h01);
      wr(8'h02, 8'h00);
      chk("off2 share", 1'b0, buck2OutputOff);
      chk("go2 share", 1'b1, buck2GoFlag);
      ticks(7);
      chk("code2 share", 7'h07, buck2VoltageCode);
      chk("mv2 share", 11'h2EE, buck2TargetMv);
      chk("skip2 share", 1'b1, buck2PulseSkipSwitching);
      currentShareMode = 1'b0;
      cyc(10);
      chk("off2 alone", 1'b1, buck2OutputOff);
   endtask

   task automatic healthScen();
      overTemp = 1'b1;
      output2InRegulation = 1'b1;
      cyc(10);
      rdChk(8'h04, 8'h06);
      overTemp = 1'b0;
      output1InRegulation = 1'b1;
      cyc(10);
      rdChk(8'h04, 8'h03);
   endtask

   task automatic addrScen();
      logic [6:0] bad [4] = '{7'h00, 7'h78, 7'h60, 7'h63};
      for (int b = 0; b < 4; b++) begin
         i_dbv_bus_master.writeReg(bad[b], 8'h00, 8'h00, ok);
         chk("foreign ack", 1'b0, ok);
      end
      rdChk(8'h00, 8'h87);
      for (int s = 0; s < 3; s++) begin
         doReset(s == 0, s == 2);
         dev = 7'h60 + 7'(s);
         wr(8'h00, 8'h81);
         i_dbv_bus_master.writeReg(7'h60 + 7'((s + 1) % 3), 8'h00,
                                   8'h00, ok);
         chk("strap ack", 1'b0, ok);
         rdChk(8'h00, 8'h81);
      end
   endtask

   initial begin
      mismatches = 0;
      compares = 0;
      core_clk = 1'b0;
      rst = 1'b1;
      {addrPinGround, addrPinHigh, currentShareMode, modePinPulseSkip} = 4'h0;
      {overTemp, output1InRegulation, output2InRegulation} = 3'h0;
      switchClk = 1'b0;
      buck1EnablePin = 1'b1;
      buck2EnablePin = 1'b1;
      dev = 7'h61;
      doReset(1'b0, 1'b0);
      resetScen();
      goScen();
      slewScen();
      modeScen();
      shutScen();
      shareScen();
      healthScen();
      addrScen();
      end_of_test();
   end
endmodule
`default_nettype wire
